// [src/pvel_edge_det.v]
`timescale 1ns/1ps
`default_nettype none
module pvel_edge_det (
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  input  wire [7:0] src,
  output wire [7:0] chg
);
  reg [7:0] prev_q;
  // previous source values, one flop per bit
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (rst) begin
          prev_q[i] <= 1'b0;
        end else if (ce) begin
          prev_q[i] <= src[i];
        end
      end
      assign chg[i] = src[i] ^ prev_q[i];
    end
  endgenerate
endmodule
`default_nettype wire

// [src/pvel_event_latch.v]
// Operation
// - a latch bit other than 3:2 sets on any unmasked change of its source; masked changes ignored
// - a link read of the latch register clears all its bits except those set by an unmasked event in the same cycle
// - entering low power mode clears all latch bits except those set by an unmasked event in the same cycle
// - entering serial mode clears all latch bits but those set by an event in the same cycle, whatever clock suspend control says
// - bit 7 sets on unmasked bus power monitor event, read clears
// - bit 6 sets on unmasked regulator input monitor event, read clears
// - bit 5 sets on unmasked autoresume watchdog expiry, read clears
// - bit 4 sets on unmasked id_line_float_detect detect event, read clears
// - bits 3:2 record adapter detect event code; 00 means no event
// - bit 0 sets on unmasked b session valid event; bit 1 reads zero
// - charger control register at 0x85 with documented field layout, read/write
// - bit 4 of charger control enables charger detection machine
`timescale 1ns/1ps
`default_nettype none
`include "pvel_map.vh"
module pvel_event_latch (
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  input  wire [7:0] reg_addr,
  input  wire       reg_rd,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output reg        reg_hit,
  input  wire       bus_power_monitor,
  input  wire       regulator_input_monitor,
  input  wire       autoresume_watchdog_expiry,
  input  wire       id_line_float_detect,
  input  wire [1:0] adapter_detect_status,
  input  wire       b_session_valid_comparator,
  input  wire [7:0] event_mask,
  input  wire       low_power_mode,
  input  wire       serial_mode,
  input  wire       clock_suspend_control,
  output wire       data_line_current_source_enable,
  output wire       id_weak_pullup_sample_enable,
  output wire       charger_detect_machine_enable,
  output wire       data_contact_detect_enable,
  output wire [2:0] regulator_voltage_select
);
  reg  [7:0] latch_q;
  reg  [7:0] latch_d;
  reg  [6:0] chg_ctrl_q;
  reg        lpm_q;
  reg        ser_q;
  wire [7:0] src;
  wire [7:0] chg;
  wire [7:0] ev;
  wire       rd_latch;
  wire       mode_clr;

  // gather sources into latch bit order; bit 1 has no source
  assign src = {bus_power_monitor, regulator_input_monitor, autoresume_watchdog_expiry,
                id_line_float_detect, adapter_detect_status, 1'b0, b_session_valid_comparator};

  pvel_edge_det u_edge (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .src (src),
    .chg (chg)
  );

  // unmasked changes only; mask bit high means enabled
  assign ev = chg & event_mask & ~(8'h01 << `PVEL_BIT_RSVD);

  assign rd_latch = reg_rd && (reg_addr == `PVEL_OFS_LATCH);
  // clock suspend control is ignored on purpose for serial entry
  assign mode_clr = (low_power_mode && !lpm_q) || (serial_mode && !ser_q);

  // next latch value: clears first, then set wins so nothing is lost
  always @* begin
    latch_d = latch_q;
    if (rd_latch || mode_clr) begin
      latch_d = `PVEL_RST_LATCH;
    end
    latch_d[7:4] = latch_d[7:4] | ev[7:4];
    latch_d[0]   = latch_d[0] | ev[0];
    // adapter code: record the new status code, but never 00 as an event
    if ((ev[3] || ev[2]) && (adapter_detect_status != 2'b00)) begin
      latch_d[3:2] = adapter_detect_status;
    end
    latch_d[`PVEL_BIT_RSVD] = 1'b0;
  end

  // latch, charger control and mode-entry history
  always @(posedge clk) begin
    if (rst) begin
      latch_q    <= `PVEL_RST_LATCH;
      chg_ctrl_q <= 7'h00;
      lpm_q      <= 1'b0;
      ser_q      <= 1'b0;
    end else if (ce) begin
      latch_q <= latch_d;
      lpm_q   <= low_power_mode;
      ser_q   <= serial_mode;
      if (reg_wr && (reg_addr == `PVEL_OFS_CHG_CTRL)) begin
        chg_ctrl_q <= reg_wdata[6:0];
      end
    end
  end

  // read data registered; latch snapshot taken before the clear
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end else if (ce) begin
      reg_hit <= 1'b0;
      if (reg_rd) begin
        case (reg_addr)
          `PVEL_OFS_LATCH: begin
            reg_rdata <= latch_q;
            reg_hit   <= 1'b1;
          end
          `PVEL_OFS_CHG_CTRL: begin
            reg_rdata <= {1'b0, chg_ctrl_q}; // reserved bit 7 reads zero
            reg_hit   <= 1'b1;
          end
          default: begin
            reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

  // charger control fields out to analog front end
  assign data_line_current_source_enable = chg_ctrl_q[`PVEL_BIT_IDP_SRC];
  assign id_weak_pullup_sample_enable    = chg_ctrl_q[`PVEL_BIT_ID_WK_PU];
  assign charger_detect_machine_enable   = chg_ctrl_q[`PVEL_BIT_DET_EN];
  assign data_contact_detect_enable      = chg_ctrl_q[`PVEL_BIT_DCD_EN];
  assign regulator_voltage_select        = chg_ctrl_q[`PVEL_BIT_VSEL_HI:`PVEL_BIT_VSEL_LO];

  // clock_suspend_control has no effect here by design
  wire unused_ok = clock_suspend_control;
endmodule
`default_nettype wire

// [src/pvel_map.vh]
`ifndef PVEL_MAP_VH
`define PVEL_MAP_VH
// register offsets on the phy register port
`define PVEL_OFS_LATCH      8'h84
`define PVEL_OFS_CHG_CTRL   8'h85
// latch register field positions
`define PVEL_BIT_BUS_PWR    7
`define PVEL_BIT_REG_IN     6
`define PVEL_BIT_WDOG       5
`define PVEL_BIT_ID_LINE_FLOAT_DETECT   4
`define PVEL_BIT_ACA_HI     3
`define PVEL_BIT_ACA_LO     2
`define PVEL_BIT_RSVD       1
`define PVEL_BIT_BVALID     0
// charger control field positions
`define PVEL_BIT_CHG_RSVD   7
`define PVEL_BIT_IDP_SRC    6
`define PVEL_BIT_ID_WK_PU   5
`define PVEL_BIT_DET_EN     4
`define PVEL_BIT_DCD_EN     3
`define PVEL_BIT_VSEL_HI    2
`define PVEL_BIT_VSEL_LO    0
// reset values
`define PVEL_RST_LATCH      8'h00
`define PVEL_RST_CHG_CTRL   8'h00
`endif

// [test/pvel_event_latch_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pvel_event_latch_tb;
  logic clk = 1'b0, rst = 1'b1, lpm = 1'b0, ser = 1'b0, csc = 1'b0, rd, wr, hit, idp, idw, det, dcd;
  logic ce = 1'b1;
  logic [7:0] src = 8'h00, mask = 8'hff, rdata, addr, wdata;
  logic [2:0] vsel;
  int error_cnt = 0, checks = 0;
  always #50 clk = ~clk;
  pvel_link_model link (.clk(clk), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wdata));
  pvel_event_latch DUT (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit), .bus_power_monitor(src[7]),
    .regulator_input_monitor(src[6]), .autoresume_watchdog_expiry(src[5]), .id_line_float_detect(src[4]),
    .adapter_detect_status(src[3:2]), .b_session_valid_comparator(src[0]), .event_mask(mask),
    .low_power_mode(lpm), .serial_mode(ser), .clock_suspend_control(csc),
    .data_line_current_source_enable(idp), .id_weak_pullup_sample_enable(idw),
    .charger_detect_machine_enable(det), .data_contact_detect_enable(dcd), .regulator_voltage_select(vsel));
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // read, then compare data and the hit flag while it stands
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    link.xfer(1'b0, a, 8'h00);
    chk(rdata, exp, "rdata");
    chk({7'h00, hit}, {7'h00, a == 8'h84 || a == 8'h85}, "hit");
  endtask
  // one source at a time; adapter 00 to 10 loads code 10
  task t_events;
    logic [47:0] m;
    m = 48'h80_40_20_10_08_01;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk) src = src ^ m[47-8*i -: 8];
      rd_chk(8'h84, m[47-8*i -: 8]);
      rd_chk(8'h84, 8'h00);
    end
    @(negedge clk) {mask, src} = {8'h00, src ^ 8'h81};
    rd_chk(8'h84, 8'h00);
    @(negedge clk) {mask, src} = {8'h80, src ^ 8'hc0};
    rd_chk(8'h84, 8'h80);
    mask = 8'hff;
    $display("events done");
  endtask
  // a pending event must not survive mode entry
  task t_modes;
    @(negedge clk) src = src ^ 8'h80;
    @(negedge clk) lpm = 1'b1;
    rd_chk(8'h84, 8'h00);
    @(negedge clk) {lpm, csc, src} = {2'b01, src ^ 8'h40};
    @(negedge clk) ser = 1'b1;
    rd_chk(8'h84, 8'h00);
    $display("modes done");
  endtask
  task t_ctrl;
    rd_chk(8'h85, 8'h00);
    link.xfer(1'b1, 8'h85, 8'h5d);
    rd_chk(8'h85, 8'h5d);
    chk({1'b0, idp, idw, det, dcd, vsel}, 8'h5d, "pins");
    link.xfer(1'b1, 8'h84, 8'hff);
    rd_chk(8'h84, 8'h00);
    rd_chk(8'h90, 8'h00);
    $display("ctrl done");
  endtask
  // frozen enable takes no read; an event meeting a read survives it
  task t_freeze;
    @(negedge clk) {ce, src} = {1'b0, src ^ 8'h01};
    link.xfer(1'b0, 8'h84, 8'h00);
    chk({7'h00, hit}, 8'h00, "frozen hit");
    @(negedge clk) ce = 1'b1;
    rd_chk(8'h84, 8'h01);
    fork
      begin
        @(negedge clk) src = src ^ 8'h10;
      end
      link.xfer(1'b0, 8'h84, 8'h00);
    join
    chk(rdata, 8'h00, "pre clear");
    rd_chk(8'h84, 8'h10);
    $display("freeze done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_ctrl;
    t_events;
    t_modes;
    t_freeze;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// [test/pvel_link_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pvel_link_model (
  input  wire           clk,
  output var logic [7:0] reg_addr,
  output var logic       reg_rd,
  output var logic       reg_wr,
  output var logic [7:0] reg_wdata
);
  initial {reg_addr, reg_rd, reg_wr, reg_wdata} = 18'h0;
  // strobe held across the sampling edge, dropped half a period later
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clk);
    {reg_wr, reg_rd} = 2'b00;
  endtask
endmodule
`default_nettype wire

// [test/pvel_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module pvel_monitor (
  input wire       clk,
  input wire       rst,
  input wire       ce,
  input wire [7:0] reg_addr,
  input wire       reg_rd,
  input wire       reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       reg_hit,
  input wire       charger_detect_machine_enable,
  input wire [2:0] regulator_voltage_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // qualified strobes; a frozen clock enable takes no request
  wire rd = reg_rd && ce;
  wire wc = reg_wr && ce && reg_addr == 8'h85;
  wire mapped = reg_addr == 8'h84 || reg_addr == 8'h85;
  hit_map_a: assert property (rd && mapped |=> reg_hit) else $error("no hit");
  miss_zero_a: assert property (rd && !mapped |=> !reg_hit && reg_rdata == 8'h00) else $error("miss");
  hit_only_a: assert property (!rd |=> !reg_hit) else $error("stray hit");
  rsv_zero_a: assert property (rd && reg_addr == 8'h84 |=> !reg_rdata[1]) else $error("bit1");
  det_wr_a: assert property (wc |=> charger_detect_machine_enable == $past(reg_wdata[4])) else $error("det");
  vsel_wr_a: assert property (wc |=> regulator_voltage_select == $past(reg_wdata[2:0])) else $error("vsel");
  vsel_rd_a: assert property (rd && reg_addr == 8'h85 |=> reg_rdata[2:0] == $past(regulator_voltage_select))
    else $error("vsel rd");
  rdata_hold_a: assert property (!rd |=> $stable(reg_rdata)) else $error("rdata moved");
  cover property (rd && reg_addr == 8'h84);
  cover property (wc);
  cover property (rd && !mapped);
endmodule
bind pvel_event_latch pvel_monitor u_mon (.*);
`default_nettype wire
